//--- rtl/console_time_of_day_counter.sv
// Time-of-day counter with panel switches, fault lamps, use-time meter and bus slave
//
// Overview of operation
// - Time is six decimal digits, hours then minutes then hundredths of a minute, shown on the display outputs.
// - The count runs over 24 hours and rolls from 23:59.99 to 00:00.00 on its own.
// - The start switch puts the counter into the running state, advancing once per hundredth of a minute.
// - The stop switch halts counting and holds the value so the digits can be set.
// - The clear switch forces all time digits to zero.
// - Six step switches, two for hours and four for minutes and hundredths, each advance their own digit by one.
// - The clock fault reset switch turns off the clock fault lamp.
// - All ten clock switches are ignored while the processor real-time lockout is asserted.
// - The panel-wide fault clear turns off every other fault lamp but leaves the clock fault lamp as it is.
// - The use-time meter accumulates only while the processor runs and holds otherwise.
// - The use-time meter counts hours with two fraction digits and wraps from 9999.99 to 0000.00.
// - A sensed supply transient lights the clock fault lamp.
// - The clock-disabled lamp is lit while the clock request and interrupt lines are disabled.
`timescale 1ns/1ps
module console_time_of_day_counter
  import tod_pkg::*;
#(
  parameter logic [TICK_W-1:0] TICK_CYCLES = TICK_W'(TICK_CYCLES_DEF),
  parameter logic [METER_W-1:0] METER_CYCLES = METER_W'(METER_CYCLES_DEF)
)
(
  input wire logic core_clk,
  input wire logic rstn,
  // Panel switches, lockout and status pins
  input wire logic [SW_COUNT-1:0] clock_switches,
  input wire logic real_time_lock,
  input wire logic supply_transient,
  input wire logic [OTHER_FAULTS-1:0] fault_events,
  input wire logic panel_fault_clear,
  input wire logic clock_lines_disabled,
  input wire logic cpu_running,
  // Lamps and displays
  output logic [TIME_W-1:0] time_digits,
  output logic [TIME_W-1:0] meter_digits,
  output logic clock_fault_lamp,
  output logic [OTHER_FAULTS-1:0] fault_lamps,
  output logic clock_disabled_lamp,
  output logic irq,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);

  // ********************************************************
  // Input synchronisers
  // ********************************************************
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic [SYNC_W-1:0] pins;
  logic panel_meta_r;
  logic panel_sync_r;
  logic panel_prev_r;
  logic [SW_COUNT-1:0] sw_prev_r;
  assign pins = {cpu_running, clock_lines_disabled, fault_events, supply_transient, real_time_lock, clock_switches};
  // Two stages for every pin, then an edge history stage for the ten switches and the panel clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
      sw_prev_r <= '0;
      panel_meta_r <= 1'b0;
      panel_sync_r <= 1'b0;
      panel_prev_r <= 1'b0;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      sw_prev_r <= sync_r[SW_COUNT-1:0];
      panel_meta_r <= panel_fault_clear;
      panel_sync_r <= panel_meta_r;
      panel_prev_r <= panel_sync_r;
    end
  end

  // ********************************************************
  // Switch press decode
  // ********************************************************
  wire lock_s;
  wire transient_s;
  wire lines_off_s;
  wire cpu_run_s;
  wire [OTHER_FAULTS-1:0] fault_s;
  wire [SW_COUNT-1:0] press;
  wire panel_clear_press;
  assign lock_s = sync_r[PIN_LOCK];
  assign transient_s = sync_r[PIN_TRANSIENT];
  assign lines_off_s = sync_r[PIN_LINES_OFF];
  assign cpu_run_s = sync_r[PIN_CPU_RUN];
  assign fault_s = sync_r[PIN_FAULT0 +: OTHER_FAULTS];
  // One pulse per press, none while locked out
  assign press = sync_r[SW_COUNT-1:0] & ~sw_prev_r & {SW_COUNT{~lock_s}};
  assign panel_clear_press = panel_sync_r & ~panel_prev_r;

  // ********************************************************
  // Run state
  // ********************************************************
  clk_state_type state_r;
  clk_state_type state_nxt;
  // Start wins when both are pressed in one cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CLK_STOPPED: begin
        if (press[SW_START]) begin
          state_nxt = CLK_RUNNING;
        end
      end
      CLK_RUNNING: begin
        if (press[SW_STOP] && !press[SW_START]) begin
          state_nxt = CLK_STOPPED;
        end
      end
      default: begin
        state_nxt = CLK_STOPPED;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= CLK_STOPPED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ********************************************************
  // Hundredth-minute tick
  // ********************************************************
  logic [TICK_W-1:0] tick_cnt_r;
  wire running;
  wire tick;
  assign running = (state_r == CLK_RUNNING);
  assign tick = running && (tick_cnt_r == TICK_CYCLES - TICK_W'(1));
  // Divider halts with the clock and restarts on clear
  always_ff @(posedge core_clk) begin
    if (!rstn || press[SW_CLEAR] || tick) begin
      tick_cnt_r <= '0;
    end else if (running) begin
      tick_cnt_r <= tick_cnt_r + TICK_W'(1);
    end
  end

  // ********************************************************
  // Time digit chain
  // ********************************************************
  digit_if tif[DIGITS] ();
  wire [DIGITS-1:0] tcarry;
  wire [DIG_W-1:0] hour_units_top;
  // Hour units stop at 3 in the twenties
  assign hour_units_top = (tif[DIG_HOUR_T].value == LIM_TWO) ? LIM_THREE : LIM_NINE;
  genvar gi;
  generate
    for (gi = 0; gi < DIGITS; gi++) begin : g_time
      assign tif[gi].step = press[SW_STEP0 + gi];
      assign tif[gi].clr = press[SW_CLEAR];
      if (gi == DIG_HUND_U) begin : g_first
        assign tif[gi].adv = tick;
      end else begin : g_next
        assign tif[gi].adv = tcarry[gi-1];
      end
      if (gi == DIG_HOUR_T) begin : g_ht
        assign tif[gi].limit = LIM_TWO;
      end else if (gi == DIG_HOUR_U) begin : g_hu
        assign tif[gi].limit = hour_units_top;
      end else if (gi == DIG_MIN_T) begin : g_mt
        assign tif[gi].limit = LIM_FIVE;
      end else begin : g_dec
        assign tif[gi].limit = LIM_NINE;
      end
      assign tcarry[gi] = tif[gi].carry;
      assign time_digits[gi*DIG_W +: DIG_W] = tif[gi].value;
      digit_counter u_tdig (
        .core_clk (core_clk),
        .rstn (rstn),
        .d (tif[gi])
      );
    end
  endgenerate

  // ********************************************************
  // Use-time meter
  // ********************************************************
  logic [METER_W-1:0] meter_cnt_r;
  wire meter_tick;
  digit_if mif[DIGITS] ();
  wire [DIGITS-1:0] mcarry;
  assign meter_tick = cpu_run_s && (meter_cnt_r == METER_CYCLES - METER_W'(1));
  // Prescaler advances only while the processor runs
  always_ff @(posedge core_clk) begin
    if (!rstn || meter_tick) begin
      meter_cnt_r <= '0;
    end else if (cpu_run_s) begin
      meter_cnt_r <= meter_cnt_r + METER_W'(1);
    end
  end

  generate
    for (gi = 0; gi < DIGITS; gi++) begin : g_meter
      assign mif[gi].step = 1'b0;
      assign mif[gi].clr = 1'b0;
      assign mif[gi].limit = LIM_NINE;
      if (gi == 0) begin : g_first
        assign mif[gi].adv = meter_tick;
      end else begin : g_next
        assign mif[gi].adv = mcarry[gi-1];
      end
      assign mcarry[gi] = mif[gi].carry;
      assign meter_digits[gi*DIG_W +: DIG_W] = mif[gi].value;
      digit_counter u_mdig (
        .core_clk (core_clk),
        .rstn (rstn),
        .d (mif[gi])
      );
    end
  endgenerate

  // ********************************************************
  // Fault lamps
  // ********************************************************
  logic clock_fault_r;
  logic [OTHER_FAULTS-1:0] fault_lamps_r;
  logic lines_off_r;
  // Transient sets win over the fault reset switch
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clock_fault_r <= 1'b0;
    end else if (transient_s) begin
      clock_fault_r <= 1'b1;
    end else if (press[SW_FAULT_RST]) begin
      clock_fault_r <= 1'b0;
    end
  end

  // Panel clear leaves the clock fault lamp alone; sets win
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fault_lamps_r <= '0;
    end else begin
      fault_lamps_r <= (fault_lamps_r & ~{OTHER_FAULTS{panel_clear_press}}) | fault_s;
    end
  end

  // Clock-disabled indication follows the line disable
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lines_off_r <= 1'b0;
    end else begin
      lines_off_r <= lines_off_s;
    end
  end

  assign clock_fault_lamp = clock_fault_r;
  assign fault_lamps = fault_lamps_r;
  assign clock_disabled_lamp = lines_off_r;

  // ********************************************************
  // Interrupt status and mask
  // ********************************************************
  logic [EV_W-1:0] int_stat_r;
  logic [EV_W-1:0] int_stat_nxt;
  logic [EV_W-1:0] int_mask_r;
  logic irq_r;
  wire [EV_W-1:0] events;
  wire [EV_W-1:0] w1c;
  wire bus_write;
  // A write completes in the cycle waitrequest is low
  assign bus_write = write & ~waitrequest;
  assign events = {mcarry[DIGITS-1], transient_s & ~clock_fault_r, tcarry[DIGITS-1]};
  assign w1c = (bus_write && address == REG_INT_STAT && byteenable[0]) ? writedata[EV_W-1:0] : EV_NONE;
  // New events win over a clear in the same cycle
  assign int_stat_nxt = (int_stat_r & ~w1c) | events;

  // Status, mask and interrupt line
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      int_stat_r <= EV_NONE;
      int_mask_r <= EV_NONE;
      irq_r <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      irq_r <= |(int_stat_r & int_mask_r);
      if (bus_write && address == REG_INT_MASK && byteenable[0]) begin
        int_mask_r <= writedata[EV_W-1:0];
      end
    end
  end

  assign irq = irq_r;

  // ********************************************************
  // Avalon-MM slave
  // ********************************************************
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  wire [31:0] status_word;
  assign status_word = {27'h0, cpu_run_s, lock_s, lines_off_r, clock_fault_r, running};
  // Read data selection; unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0;
    case (address)
      REG_TIME: rd_mux = {8'h0, time_digits};
      REG_METER: rd_mux = {8'h0, meter_digits};
      REG_STATUS: rd_mux = status_word;
      REG_INT_STAT: rd_mux = {29'h0, int_stat_r};
      REG_INT_MASK: rd_mux = {29'h0, int_mask_r};
      default: rd_mux = 32'h0;
    endcase
  end

  // One wait cycle, then a one-cycle answer
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r <= ~((read | write) & wait_r);
      if (read && wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign waitrequest = wait_r;
  assign readdata = rdata_r;

endmodule

//--- rtl/tod_pkg.sv
// Shared constants and types for the console time-of-day counter
package tod_pkg;

  // ********************************************************
  // Clock and timing
  // ********************************************************
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_MS = 600;
  localparam int unsigned TICK_CYCLES_DEF = CLK_KHZ * TICK_MS;
  localparam int unsigned METER_S = 36;
  localparam int unsigned METER_CYCLES_DEF = CLK_HZ * METER_S;
  localparam int TICK_W = 24;
  localparam int METER_W = 30;

  // ********************************************************
  // Digits
  // ********************************************************
  localparam int DIGITS = 6;
  localparam int DIG_W = 4;
  localparam int TIME_W = 24;
  localparam logic [DIG_W-1:0] DIG_ZERO = 4'h0;
  localparam logic [DIG_W-1:0] DIG_ONE = 4'h1;
  localparam logic [DIG_W-1:0] LIM_NINE = 4'h9;
  localparam logic [DIG_W-1:0] LIM_FIVE = 4'h5;
  localparam logic [DIG_W-1:0] LIM_THREE = 4'h3;
  localparam logic [DIG_W-1:0] LIM_TWO = 4'h2;
  localparam int DIG_HUND_U = 0;
  localparam int DIG_MIN_T = 3;
  localparam int DIG_HOUR_U = 4;
  localparam int DIG_HOUR_T = 5;

  // ********************************************************
  // Switch and pin layout
  // ********************************************************
  localparam int SW_COUNT = 10;
  localparam int SW_FAULT_RST = 0;
  localparam int SW_START = 1;
  localparam int SW_STOP = 2;
  localparam int SW_CLEAR = 3;
  localparam int SW_STEP0 = 4;
  localparam int OTHER_FAULTS = 8;
  localparam int SYNC_W = 22;
  localparam int PIN_LOCK = 10;
  localparam int PIN_TRANSIENT = 11;
  localparam int PIN_FAULT0 = 12;
  localparam int PIN_LINES_OFF = 20;
  localparam int PIN_CPU_RUN = 21;

  // ********************************************************
  // Register map (word index on the bus)
  // ********************************************************
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] REG_TIME = 3'h0;
  localparam logic [ADDR_W-1:0] REG_METER = 3'h1;
  localparam logic [ADDR_W-1:0] REG_STATUS = 3'h2;
  localparam logic [ADDR_W-1:0] REG_INT_STAT = 3'h3;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 3'h4;
  localparam int ST_RUN = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_LINES_OFF = 2;
  localparam int ST_LOCK = 3;
  localparam int ST_CPU_RUN = 4;
  localparam int EV_W = 3;
  localparam int EV_ROLL = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_METER_WRAP = 2;
  localparam logic [EV_W-1:0] EV_NONE = 3'h0;

  // ********************************************************
  // Run state of the counter
  // ********************************************************
  typedef enum logic [1:0] {
    CLK_STOPPED = 2'b01,
    CLK_RUNNING = 2'b10
  } clk_state_type;

endpackage

//--- rtl/digit_if.sv
// Signals between the counter control and one decimal digit
`timescale 1ns/1ps
interface digit_if;
  import tod_pkg::*;
  logic step;
  logic adv;
  logic clr;
  logic [DIG_W-1:0] limit;
  logic [DIG_W-1:0] value;
  logic carry;
  modport ctl (output step, output adv, output clr, output limit, input value, input carry);
  modport dig (input step, input adv, input clr, input limit, output value, output carry);
endinterface

//--- rtl/digit_counter.sv
// One decimal digit with variable top value and carry out
`timescale 1ns/1ps
module digit_counter
  import tod_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  digit_if.dig d
);

  logic [DIG_W-1:0] value_r;
  logic [DIG_W-1:0] value_nxt;
  wire at_top;
  wire bump;

  // Wrap at or beyond the top, carry only on chain advance
  assign at_top = (value_r >= d.limit);
  assign bump = d.step | d.adv;
  assign value_nxt = at_top ? DIG_ZERO : value_r + DIG_ONE;
  assign d.value = value_r;
  assign d.carry = d.adv & at_top;

  // Digit register
  always_ff @(posedge core_clk) begin
    if (!rstn || d.clr) begin
      value_r <= DIG_ZERO;
    end else if (bump) begin
      value_r <= value_nxt;
    end
  end

endmodule

//--- tb/tod_chk.sv
// Port-level assertions for the time-of-day counter
`timescale 1ns/1ps
module tod_chk
  import tod_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [SW_COUNT-1:0] clock_switches,
  input wire logic real_time_lock,
  input wire logic supply_transient,
  input wire logic [OTHER_FAULTS-1:0] fault_events,
  input wire logic panel_fault_clear,
  input wire logic clock_lines_disabled,
  input wire logic cpu_running,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [TIME_W-1:0] time_digits,
  input wire logic [TIME_W-1:0] meter_digits,
  input wire logic clock_fault_lamp,
  input wire logic [OTHER_FAULTS-1:0] fault_lamps,
  input wire logic clock_disabled_lamp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // **********************************
  // Properties
  // **********************************
  property p_bus_answer;
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  property p_time_legal;
    time_digits[3:0] <= 4'h9 && time_digits[7:4] <= 4'h9 && time_digits[11:8] <= 4'h9 && time_digits[15:12] <= 4'h5;
  endproperty
  property p_roll;
    $past(time_digits) == 24'h235999 && $past(clock_switches, 2) == 10'h000 && $past(clock_switches, 3) == 10'h000
      |-> time_digits inside {24'h235999, 24'h000000};
  endproperty
  property p_fault_set;
    supply_transient [*5] |-> clock_fault_lamp;
  endproperty
  property p_fault_keep;
    $fell(clock_fault_lamp) |-> $past(clock_switches[SW_FAULT_RST], 2);
  endproperty
  property p_lock;
    real_time_lock [*6] |-> !$fell(clock_fault_lamp);
  endproperty
  property p_panel_clear;
    $rose(panel_fault_clear) ##0 (panel_fault_clear && fault_events == 8'h00) [*5] |-> fault_lamps == 8'h00;
  endproperty
  property p_lines;
    $past(rstn, 3) && $past(rstn, 2) |-> clock_disabled_lamp == $past(clock_lines_disabled, 3);
  endproperty
  property p_meter_hold;
    !cpu_running [*5] |-> $stable(meter_digits);
  endproperty
  property p_meter_step;
    $changed(meter_digits) |-> meter_digits[3:0] == ($past(meter_digits[3:0]) == 4'h9 ? 4'h0 : $past(meter_digits[3:0]) + 4'h1);
  endproperty

  // **********************************
  // Assertions and covers
  // **********************************
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");
  a_time_legal: assert property (p_time_legal) else $error("time digit out of range");
  a_roll: assert property (p_roll) else $error("day rollover wrong");
  a_fault_set: assert property (p_fault_set) else $error("fault lamp not set");
  a_fault_keep: assert property (p_fault_keep) else $error("fault lamp cleared without switch");
  a_lock: assert property (p_lock) else $error("switch honoured under lockout");
  a_panel_clear: assert property (p_panel_clear) else $error("panel lamps not cleared");
  a_lines: assert property (p_lines) else $error("disabled lamp wrong");
  a_meter_hold: assert property (p_meter_hold) else $error("meter moved while idle");
  a_meter_step: assert property (p_meter_step) else $error("meter step wrong");
  c_roll: cover property ($past(time_digits) == 24'h235999 && time_digits == 24'h000000);
  c_fault_clear: cover property ($fell(clock_fault_lamp));
  c_meter: cover property ($changed(meter_digits));
endmodule

//--- tb/tod_panel.sv
// Operator switch panel and real-time lockout model
`timescale 1ns/1ps
module tod_panel
  import tod_pkg::*;
(
  input wire logic core_clk,
  output logic [SW_COUNT-1:0] clock_switches,
  output logic real_time_lock
);
  // Switches rest open
  initial begin
    clock_switches = 10'h000;
    real_time_lock = 1'b0;
  end

  // Momentary presses, held and released four cycles each
  task automatic press(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      clock_switches[idx] <= 1'b1;
      repeat (4) @(posedge core_clk);
      clock_switches[idx] <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask

  // Lockout level, given time to settle
  task automatic set_lock(input logic v);
    @(posedge core_clk);
    real_time_lock <= v;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

//--- tb/console_time_of_day_counter_test.sv
// Self-checking bench for the console time-of-day counter
`timescale 1ns/1ps
module console_time_of_day_counter_test;
  import tod_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [SW_COUNT-1:0] clock_switches;
  logic real_time_lock;
  logic supply_transient = 1'b0;
  logic [OTHER_FAULTS-1:0] fault_events = 8'h00;
  logic panel_fault_clear = 1'b0;
  logic clock_lines_disabled = 1'b0;
  logic cpu_running = 1'b0;
  logic [TIME_W-1:0] time_digits;
  logic [TIME_W-1:0] meter_digits;
  logic clock_fault_lamp;
  logic [OTHER_FAULTS-1:0] fault_lamps;
  logic clock_disabled_lamp;
  logic irq;
  logic [ADDR_W-1:0] address = 3'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic [3:0] dig [DIGITS];
  logic [31:0] d;
  logic [7:0] p;
  int mismatches = 0;
  int comparisons = 0;

  always #20 core_clk = ~core_clk;

  tod_panel i_panel (.core_clk(core_clk), .clock_switches(clock_switches), .real_time_lock(real_time_lock));

  console_time_of_day_counter #(.TICK_CYCLES(24'h000004), .METER_CYCLES(30'h00000005)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .clock_switches(clock_switches), .real_time_lock(real_time_lock),
    .supply_transient(supply_transient), .fault_events(fault_events), .panel_fault_clear(panel_fault_clear),
    .clock_lines_disabled(clock_lines_disabled), .cpu_running(cpu_running), .time_digits(time_digits),
    .meter_digits(meter_digits), .clock_fault_lamp(clock_fault_lamp), .fault_lamps(fault_lamps),
    .clock_disabled_lamp(clock_disabled_lamp), .irq(irq), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));

  // **********************************
  // Helpers
  // **********************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    bus(1'b0, a, 32'h00000000, v);
    check(what, exp, v);
  endtask

  function automatic logic [23:0] expect_time();
    logic [23:0] t;
    for (int i = 0; i < DIGITS; i++) t[i*4 +: 4] = dig[i];
    return t;
  endfunction

  task automatic set_time();
    for (int i = 0; i < DIGITS; i++) i_panel.press(SW_STEP0 + i, int'(dig[i]));
  endtask

  // **********************************
  // Main sequence
  // **********************************
  initial begin
    void'($urandom(32'he34acfd5));
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("reset time", 32'h0, {8'h00, time_digits});
    check("idle outputs", 32'h1, {irq, clock_fault_lamp, fault_lamps, clock_disabled_lamp, waitrequest});
    for (int a = 5; a < 8; a++) begin
      bus(1'b1, a[2:0], $urandom, d);
      rd_chk(a[2:0], 32'h0, "unmapped");
    end
    bus(1'b1, REG_TIME, 32'h00123456, d);
    rd_chk(REG_TIME, 32'h0, "time read only");
    bus(1'b1, REG_INT_MASK, 32'h7, d);
    rd_chk(REG_INT_MASK, 32'h7, "mask");
    // Write with the low lane disabled must leave the mask alone
    byteenable <= {3'($urandom), 1'b0};
    bus(1'b1, REG_INT_MASK, 32'h0, d);
    byteenable <= 4'hf;
    rd_chk(REG_INT_MASK, 32'h7, "mask kept");
    bus(1'b1, REG_INT_MASK, 32'h0, d);
    for (int i = 0; i < DIGITS; i++) dig[i] = 4'($urandom_range(i == 3 ? 5 : (i == 5 ? 1 : 9)));
    set_time();
    repeat (40) @(posedge core_clk);
    check("stepped time", {8'h00, expect_time()}, {8'h00, time_digits});
    i_panel.set_lock(1'b1);
    i_panel.press(SW_CLEAR, 1);
    i_panel.press(SW_START, 1);
    i_panel.press(SW_STEP0, 1);
    repeat (20) @(posedge core_clk);
    check("locked time", {8'h00, expect_time()}, {8'h00, time_digits});
    i_panel.set_lock(1'b0);
    i_panel.press(SW_CLEAR, 1);
    check("cleared", 32'h0, {8'h00, time_digits});
    dig = '{4'h9, 4'h9, 4'h9, 4'h5, 4'h3, 4'h2};
    set_time();
    check("last minute", 32'h00235999, {8'h00, time_digits});
    i_panel.press(SW_START, 1);
    repeat (8) @(posedge core_clk);
    check("rolled", 32'h0, {16'h0000, time_digits[23:8]});
    rd_chk(REG_STATUS, 32'h1, "running");
    rd_chk(REG_INT_STAT, 32'h1, "roll event");
    check("masked irq", 32'h0, {31'h0, irq});
    bus(1'b1, REG_INT_MASK, 32'h1, d);
    repeat (3) @(posedge core_clk);
    check("irq", 32'h1, {31'h0, irq});
    bus(1'b1, REG_INT_STAT, 32'h1, d);
    repeat (3) @(posedge core_clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    i_panel.press(SW_STOP, 1);
    i_panel.press(SW_CLEAR, 1);
    repeat (40) @(posedge core_clk);
    check("stopped", 32'h0, {8'h00, time_digits});
    rd_chk(REG_STATUS, 32'h0, "stopped status");
    supply_transient <= 1'b1;
    repeat (5) @(posedge core_clk);
    supply_transient <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("fault lamp", 32'h1, {31'h0, clock_fault_lamp});
    p = 8'($urandom_range(1, 255));
    fault_events <= p;
    repeat (5) @(posedge core_clk);
    fault_events <= 8'h00;
    repeat (4) @(posedge core_clk);
    check("panel lamps", {24'h0, p}, {24'h0, fault_lamps});
    rd_chk(REG_INT_STAT, 32'h2, "fault event");
    check("masked fault irq", 32'h0, {31'h0, irq});
    panel_fault_clear <= 1'b1;
    repeat (5) @(posedge core_clk);
    panel_fault_clear <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("panel clear", 32'h100, {23'h0, clock_fault_lamp, fault_lamps});
    i_panel.set_lock(1'b1);
    i_panel.press(SW_FAULT_RST, 1);
    check("locked fault reset", 32'h1, {31'h0, clock_fault_lamp});
    i_panel.set_lock(1'b0);
    i_panel.press(SW_FAULT_RST, 1);
    check("fault reset", 32'h0, {31'h0, clock_fault_lamp});
    clock_lines_disabled <= 1'b1;
    repeat (5) @(posedge core_clk);
    check("lines lamp on", 32'h1, {31'h0, clock_disabled_lamp});
    clock_lines_disabled <= 1'b0;
    repeat (5) @(posedge core_clk);
    check("lines lamp off", 32'h0, {31'h0, clock_disabled_lamp});
    cpu_running <= 1'b1;
    repeat (37) @(posedge core_clk);
    cpu_running <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("meter", 32'h7, {8'h00, meter_digits});
    repeat (20) @(posedge core_clk);
    check("meter held", 32'h7, {8'h00, meter_digits});
    conclude();
  end
endmodule

bind console_time_of_day_counter tod_chk i_chk (.*);
